// ===== pds_pkg.sv
// Purpose: Shared constants and types for the peak detect and select stage.
// Assumes: 12-bit spectral samples, at most six peaks per frame.
// Notes: Refractive indices are unsigned Q2.14, so 1.0 is 16'h4000.
package pds_pkg;
    // Frame geometry and detection scaling.
    localparam int MAX_PEAKS = 6;
    localparam logic [2:0] MAX_CNT = 3'h6;
    localparam logic [18:0] PCT_FULL = 19'h00064;
    localparam logic [18:0] FULL_SCALE = 19'h00FFF;

    // Register byte offsets; table entries are two words each.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LAYER = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam logic [7:0] REG_INDEX = 8'h10;
    localparam logic [2:0] MAT_PAGE = 3'h1;

    // Single-value policies.
    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] SEL_HIGHEST = 2'h1;
    localparam logic [1:0] SEL_LAST = 2'h2;
    // Two-value pairings.
    localparam logic [1:0] PAIR_FIRST_SECOND = 2'h0;
    localparam logic [1:0] PAIR_FIRST_LAST = 2'h1;
    localparam logic [1:0] PAIR_TOP_TWO = 2'h2;
    localparam logic [1:0] PAIR_LAST_TWO = 2'h3;

    // Material entry forms.
    localparam logic MAT_KIND_THREE = 1'b0;
    localparam logic MAT_KIND_ABBE = 1'b1;
    localparam logic [15:0] N_ONE = 16'h4000;

    // Control word, bits [14:0] of the control register.
    typedef struct packed {
        logic [2:0] layers;
        logic corr_en;
        logic [1:0] policy;
        logic dual;
        logic pad;
        logic [6:0] thr;
    } pds_ctrl_t;

    // Threshold 2 %, highest peak, correction off, no layers.
    localparam logic [14:0] CTRL_RST = 15'h0202;
    localparam logic [11:0] LAYER_RST = 12'h000;

    typedef struct packed {
        logic first;
        logic last;
        logic [11:0] dark;
        logic [11:0] light;
    } pds_sample_t;

    typedef struct packed {
        logic [11:0] pos;
        logic [11:0] height;
    } pds_peak_t;

    // Word A: kind in bit 16, nd below; word B: nF or Abbe high, nC low.
    typedef struct packed {
        logic kind;
        logic [15:0] nd;
        logic [15:0] nf_abbe;
        logic [15:0] nc;
    } pds_mat_t;

    localparam logic [48:0] MAT_RST = {MAT_KIND_THREE, N_ONE, N_ONE, N_ONE};
endpackage

// ===== pds_peak_scan.sv
// Purpose: Finds runs above the detection threshold and reports one peak each.
// Assumes: One sample per valid cycle, frames framed by first and last flags.
// Notes: Outputs are registered; a peak closed at the frame end shares its cycle with frame_done.
`timescale 1ns/1ps
module pds_peak_scan
    import pds_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [6:0] thr_pct_i,
    input wire logic sample_valid_i,
    input wire pds_sample_t sample_i,
    output pds_peak_t peak_o,
    output logic peak_valid_o,
    output logic frame_done_o
);
    logic in_run;
    logic [11:0] pos_cnt;
    pds_peak_t best;

    // Percent compare done in integers, so no divider is needed.
    wire [18:0] lhs = 19'(sample_i.dark) * PCT_FULL;
    wire [18:0] rhs = 19'(thr_pct_i) * FULL_SCALE;
    wire above = lhs >= rhs;
    wire [11:0] cur_pos = sample_i.first ? 12'h000 : pos_cnt;
    wire starting = above & (~in_run | sample_i.first);
    wire take = above & (starting | (sample_i.light > best.height));
    wire [11:0] cur_h = take ? sample_i.light : best.height;
    wire [11:0] cur_p = take ? cur_pos : best.pos;
    wire dip = in_run & ~sample_i.first & ~above;
    wire emit = sample_valid_i & (dip | (above & sample_i.last));

    // A run ends on a dip or at the frame end; either closes the peak.
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            in_run <= 1'b0;
            pos_cnt <= 12'h000;
            best <= '0;
            peak_o <= '0;
            peak_valid_o <= 1'b0;
            frame_done_o <= 1'b0;
        end
        else
        begin
            peak_valid_o <= emit;
            frame_done_o <= sample_valid_i & sample_i.last;
            if (emit)
                peak_o <= '{pos: cur_p, height: cur_h};
            if (sample_valid_i)
            begin
                in_run <= above & ~sample_i.last;
                pos_cnt <= cur_pos + 12'h001;
                best <= '{pos: cur_p, height: cur_h};
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_frame_done_pulse: assert property (sample_valid_i && sample_i.last
        |=> frame_done_o) else $error("frame end not reported");
    a_below_no_peak: assert property (sample_valid_i
        && sample_i.first && sample_i.last && !above |=> !peak_valid_o)
        else $error("peak reported below threshold");
    a_first_pos_zero: assert property (sample_valid_i
        && sample_i.first && sample_i.last && above
        |=> peak_valid_o && peak_o.pos == 12'h000)
        else $error("single sample peak not at position zero");
endmodule

// ===== pds_mat_table.sv
// Purpose: Material table of refractive data, four entries of two words.
// Assumes: Writes arrive from the register port of the parent.
// Notes: Entries reset to vacuum so an unset layer leaves distances alone.
`timescale 1ns/1ps
module pds_mat_table
    import pds_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic [2:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [2:0] raddr_i,
    output logic [31:0] rdata_o,
    input wire logic [1:0] mat0_i,
    input wire logic [1:0] mat1_i,
    output logic [15:0] nd0_o,
    output logic [15:0] nd1_o
);
    pds_mat_t mat [4];
    wire [1:0] went = waddr_i[2:1];
    wire [1:0] rent = raddr_i[2:1];

    // Word A holds form and nd, word B the dispersion pair.
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < 4; i++)
                mat[i] <= MAT_RST;
        end
        else if (wr_i && !waddr_i[0])
        begin
            mat[went].kind <= wdata_i[16];
            mat[went].nd <= wdata_i[15:0];
        end
        else if (wr_i)
        begin
            mat[went].nf_abbe <= wdata_i[31:16];
            mat[went].nc <= wdata_i[15:0];
        end
    end

    // Read-back and lookups are plain selections.
    assign rdata_o = raddr_i[0] ? {mat[rent].nf_abbe, mat[rent].nc}
                                : {15'h0000, mat[rent].kind, mat[rent].nd};
    assign nd0_o = mat[mat0_i].nd;
    assign nd1_o = mat[mat1_i].nd;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // The read-back is only judged while the same word is still addressed,
    // since a back-to-back access may move the address on.
    a_mat_word_a: assert property (wr_i && !waddr_i[0] ##1
        raddr_i == $past(waddr_i) |-> rdata_o[16:0] == $past(wdata_i[16:0]))
        else $error("material word A not stored");
endmodule

// ===== pds_peak_select.sv
// Purpose: Peak detection, counting, selection and refraction for one line.
// Assumes: Samples are dark and light corrected upstream, one per cycle.
// Notes: Register port with one-cycle read data; no interrupt logic.
// Overview of operation
// - Peaks count if dark-corrected level meets threshold, default 2 %.
// - Expected peak count equals material transitions within the range.
// - Peaks are numbered ascending from the start of the measuring range.
// - One value: pick first, highest (default) or last peak by policy.
// - Two values: first+second, first+last, top two, or last two.
// - Peak heights and ranking come from the light-corrected signal.
// - Above two peaks, correct only when peak count equals layer count.
// - Correction uses each layer's material only while the switch is on.
// - Table entries hold one index plus Abbe number, or three indices.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pds_peak_select
    import pds_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic sample_valid_i,
    input wire pds_sample_t sample_i,
    output logic result_strobe_o,
    output logic [1:0] valid_o,
    output logic [11:0] pos0_o,
    output logic [11:0] pos1_o,
    output logic [15:0] index0_o,
    output logic [15:0] index1_o,
    output logic corr_o,
    output logic [2:0] peak_count_o
);
    pds_ctrl_t ctrl;
    logic [11:0] layer_map;
    pds_peak_t [MAX_PEAKS-1:0] pk;
    logic [2:0] cnt;
    logic eval;
    pds_peak_t peak_ev;
    logic peak_v;
    logic frame_done;
    logic [31:0] mat_rdata;
    logic [15:0] nd0;
    logic [15:0] nd1;
    logic [31:0] next_rdata;
    logic [2:0] idx0;
    logic [2:0] idx1;

    // Index of the tallest stored peak, skipping one index if asked.
    function automatic logic [2:0] best_idx(
        input pds_peak_t [MAX_PEAKS-1:0] p,
        input logic [2:0] n,
        input logic [2:0] excl
    );
        logic [2:0] b;
        logic found;
        b = 3'h0;
        found = 1'b0;
        for (int i = 0; i < MAX_PEAKS; i++)
        begin
            if (3'(i) < n && 3'(i) != excl
                && (!found || p[i].height > p[b].height))
            begin
                b = 3'(i);
                found = 1'b1;
            end
        end
        return b;
    endfunction

    // Material assigned to the layer that starts at a given peak.
    function automatic logic [1:0] layer_mat(
        input logic [11:0] map,
        input logic [2:0] idx
    );
        return map[2 * idx +: 2];
    endfunction

    pds_peak_scan u_scan (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .thr_pct_i(ctrl.thr),
        .sample_valid_i(sample_valid_i),
        .sample_i(sample_i),
        .peak_o(peak_ev),
        .peak_valid_o(peak_v),
        .frame_done_o(frame_done)
    );

    // Register decode.
    wire is_mat = addr_i[7:5] == MAT_PAGE && addr_i[1:0] == 2'h0;
    wire wr_ctrl = wr_i && addr_i == REG_CTRL;
    wire wr_layer = wr_i && addr_i == REG_LAYER;
    wire wr_mat = wr_i && is_mat;
    wire layers_set = ctrl.layers != 3'h0;

    pds_mat_table u_table (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wr_i(wr_mat),
        .waddr_i(addr_i[4:2]),
        .wdata_i(wdata_i),
        .raddr_i(addr_i[4:2]),
        .rdata_o(mat_rdata),
        .mat0_i(layer_mat(layer_map, idx0)),
        .mat1_i(layer_mat(layer_map, idx1)),
        .nd0_o(nd0),
        .nd1_o(nd1)
    );

    // Peak storage; a peak of the next frame may land in the eval cycle,
    // so it goes to slot zero while the old set is still being read.
    wire store = peak_v && (eval || cnt < MAX_CNT);
    wire [2:0] slot = eval ? 3'h0 : cnt;
    wire [2:0] next_cnt = eval ? {2'h0, peak_v}
                        : (store ? cnt + 3'h1 : cnt);

    // Selection over the stored peaks, all ordered by position.
    wire [2:0] n = cnt;
    wire [2:0] hi1 = best_idx(pk, n, 3'h7);
    wire [2:0] hi2 = best_idx(pk, n, hi1);
    wire [2:0] last_i = n - 3'h1;
    wire [2:0] prev_i = n - 3'h2;
    wire [2:0] need = ctrl.dual ? 3'h2 : 3'h1;
    wire enough = n >= need;
    wire [1:0] next_valid = !enough ? 2'h0 : (ctrl.dual ? 2'h3 : 2'h1);

    always_comb
    begin
        idx0 = 3'h0;
        idx1 = 3'h0;
        if (!ctrl.dual)
        begin
            case (ctrl.policy)
                SEL_FIRST: idx0 = 3'h0;
                SEL_LAST: idx0 = last_i;
                default: idx0 = hi1;
            endcase
        end
        else
        begin
            case (ctrl.policy)
                PAIR_FIRST_SECOND:
                begin
                    idx0 = 3'h0;
                    idx1 = 3'h1;
                end
                PAIR_FIRST_LAST:
                begin
                    idx0 = 3'h0;
                    idx1 = last_i;
                end
                PAIR_TOP_TWO:
                begin
                    idx0 = hi1;
                    idx1 = hi2;
                end
                default:
                begin
                    idx0 = prev_i;
                    idx1 = last_i;
                end
            endcase
        end
    end

    // With more than two peaks, layers only map cleanly when the count
    // matches what software expects; otherwise indices would shift layers.
    wire count_ok = n <= 3'h2 || n == ctrl.layers;
    wire corr_now = ctrl.corr_en && count_ok && enough;
    wire [15:0] next_idx0 = corr_now ? nd0 : N_ONE;
    wire [15:0] next_idx1 = corr_now && ctrl.dual ? nd1 : N_ONE;

    // Control and layer assignment registers.
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl <= pds_ctrl_t'(CTRL_RST);
            layer_map <= LAYER_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= pds_ctrl_t'(wdata_i[14:0]);
            if (wr_layer && layers_set)
                layer_map <= wdata_i[11:0];
        end
    end

    // Peak store and frame evaluation trigger.
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pk <= '0;
            cnt <= 3'h0;
            eval <= 1'b0;
        end
        else
        begin
            eval <= frame_done;
            cnt <= next_cnt;
            if (store)
                pk[slot] <= peak_ev;
        end
    end

    // Results are captured once per frame and held until the next.
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            result_strobe_o <= 1'b0;
            valid_o <= 2'h0;
            pos0_o <= 12'h000;
            pos1_o <= 12'h000;
            index0_o <= N_ONE;
            index1_o <= N_ONE;
            corr_o <= 1'b0;
            peak_count_o <= 3'h0;
        end
        else
        begin
            result_strobe_o <= eval;
            if (eval)
            begin
                valid_o <= next_valid;
                pos0_o <= enough ? pk[idx0].pos : 12'h000;
                pos1_o <= enough && ctrl.dual ? pk[idx1].pos : 12'h000;
                index0_o <= next_idx0;
                index1_o <= next_idx1;
                corr_o <= corr_now;
                peak_count_o <= n;
            end
        end
    end

    // Read data selection; unmapped addresses read as zero.
    always_comb
    begin
        if (addr_i == REG_CTRL)
            next_rdata = {17'h00000, ctrl};
        else if (addr_i == REG_LAYER)
            next_rdata = {20'h00000, layer_map};
        else if (addr_i == REG_STATUS)
            next_rdata = {26'h0000000, corr_o, valid_o, peak_count_o};
        else if (addr_i == REG_RESULT)
            next_rdata = {4'h0, pos1_o, 4'h0, pos0_o};
        else if (addr_i == REG_INDEX)
            next_rdata = {index1_o, index0_o};
        else if (is_mat)
            next_rdata = mat_rdata;
        else
            next_rdata = 32'h00000000;
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_o <= 32'h00000000;
        else
            rdata_o <= rd_i ? next_rdata : 32'h00000000;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_eval_out;
        eval ##1 result_strobe_o;
    endsequence

    a_frame_to_result: assert property (frame_done |=> s_eval_out)
        else $error("result not produced two cycles after frame end");
    a_short_invalid: assert property (eval && n < need
        |=> valid_o == 2'h0) else $error("too few peaks but result valid");
    a_corr_mismatch: assert property (eval && n > 3'h2
        && n != ctrl.layers |=> !corr_o && index0_o == N_ONE)
        else $error("correction applied with wrong peak count");
    a_corr_switch: assert property (eval && !ctrl.corr_en
        |=> !corr_o && index1_o == N_ONE)
        else $error("correction applied while switched off");
    a_layer_lock: assert property (wr_layer && !layers_set
        |=> $stable(layer_map)) else $error("material assigned before layers");
    a_pair_order: assert property (eval && ctrl.dual
        && ctrl.policy == PAIR_FIRST_LAST && n > 3'h1
        |=> pos0_o < pos1_o) else $error("first peak not before last");
    a_top_height: assert property (eval && ctrl.dual
        && ctrl.policy == PAIR_TOP_TWO && n > 3'h1
        |-> pk[idx0].height >= pk[idx1].height)
        else $error("top two pairing out of order");
    a_read_window: assert property (!rd_i |=> rdata_o == 32'h00000000)
        else $error("read data outside read window");
endmodule

// ===== pds_peak_select_bench.sv
// Purpose: Self-checking bench for the peak detect and select stage.
// Assumes: Design assertions live in the design files; no checker here.
// Notes: Frames are short hand-built sample lists; expectations are fixed.
`timescale 1ns/1ps
module pds_peak_select_bench
    import pds_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic sample_valid_i = 1'b0;
    pds_sample_t sample_i = '0;
    logic result_strobe_o;
    logic [1:0] valid_o;
    logic [11:0] pos0_o;
    logic [11:0] pos1_o;
    logic [15:0] index0_o;
    logic [15:0] index1_o;
    logic corr_o;
    logic [2:0] peak_count_o;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [11:0] fd [16];
    logic [11:0] fl [16];

    pds_peak_select dut_u (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i),
        .result_strobe_o(result_strobe_o), .valid_o(valid_o),
        .pos0_o(pos0_o), .pos1_o(pos1_o), .index0_o(index0_o),
        .index1_o(index1_o), .corr_o(corr_o), .peak_count_o(peak_count_o)
    );

    // Free-running 50 MHz clock.
    always #10 core_clk_i = ~core_clk_i;

    // A hang is cut short well beyond the few hundred cycles needed.
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle write strobe; the write lands at the second edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe is taken.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    function automatic logic [31:0] cw(input logic [6:0] thr,
        input logic dual, input logic [1:0] pol, input logic ce,
        input logic [2:0] lay);
        return {17'h00000, lay, ce, pol, dual, 1'b0, thr};
    endfunction

    task automatic clr();
        foreach (fd[i])
        begin
            fd[i] = 12'h000;
            fl[i] = 12'h000;
        end
    endtask

    // Three one-sample peaks; darkest order differs from light order.
    task automatic mk3();
        clr();
        fd[1] = 12'hFA0;
        fl[1] = 12'h03C;
        fd[4] = 12'h12C;
        fl[4] = 12'h05A;
        fd[7] = 12'h7D0;
        fl[7] = 12'h01E;
    endtask

    // Streams n samples, then waits a bounded time for new results.
    task automatic send(input int n);
        int i;
        bit ok;
        ok = 0;
        for (i = 0; i < n; i++)
        begin
            @(posedge core_clk_i);
            sample_valid_i <= 1'b1;
            sample_i <= pds_sample_t'({i == 0, i == n - 1, fd[i], fl[i]});
        end
        @(posedge core_clk_i);
        sample_valid_i <= 1'b0;
        for (i = 0; i < 10 && !ok; i++)
        begin
            @(posedge core_clk_i);
            #1;
            if (result_strobe_o === 1'b1)
                ok = 1;
        end
        chk("strobe", {31'h0, ok}, 32'h1);
    endtask

    // Compares the result outputs; second value only in dual mode.
    task automatic res(input logic dual, input logic [1:0] v,
        input logic [11:0] p0, input logic [11:0] p1, input logic [2:0] c,
        input logic cr, input logic [15:0] i0, input logic [15:0] i1);
        chk("valid", {30'h0, valid_o}, {30'h0, v});
        chk("pos0", {20'h0, pos0_o}, {20'h0, p0});
        chk("count", {29'h0, peak_count_o}, {29'h0, c});
        chk("corr", {31'h0, corr_o}, {31'h0, cr});
        chk("index0", {16'h0, index0_o}, {16'h0, i0});
        if (dual)
        begin
            chk("pos1", {20'h0, pos1_o}, {20'h0, p1});
            chk("index1", {16'h0, index1_o}, {16'h0, i1});
        end
    endtask

    // Defaults, an unmapped read and a refused layer write.
    task automatic t_reset();
        logic [31:0] d;
        chk("index0 rst", {16'h0, index0_o}, 32'h00004000);
        rd(REG_CTRL, d);
        chk("ctrl rst", d, 32'h00000202);
        rd(8'h40, d);
        chk("unmapped", d, 32'h00000000);
        wr(REG_LAYER, 32'h00000038);
        rd(REG_LAYER, d);
        chk("layer early", d, 32'h00000000);
    endtask

    // Dark levels 81 and 82 straddle the 2 % level of full scale, in a
    // four-sample frame and then in one-sample frames.
    task automatic t_thresh();
        clr();
        fd[0] = 12'h051;
        fl[0] = 12'h0FF;
        fd[2] = 12'h052;
        fl[2] = 12'h010;
        send(4);
        res(1'b0, 2'b01, 12'h002, 12'h0, 3'h1, 1'b0, N_ONE, N_ONE);
        fd[0] = 12'h052;
        fl[0] = 12'h020;
        send(1);
        res(1'b0, 2'b01, 12'h000, 12'h0, 3'h1, 1'b0, N_ONE, N_ONE);
        fd[0] = 12'h051;
        send(1);
        res(1'b0, 2'b00, 12'h000, 12'h0, 3'h0, 1'b0, N_ONE, N_ONE);
    endtask

    // Every single-value policy on one frame of three peaks.
    task automatic t_single();
        logic [11:0] exp [4];
        int p;
        exp = '{12'h001, 12'h004, 12'h007, 12'h004};
        mk3();
        for (p = 0; p < 4; p++)
        begin
            wr(REG_CTRL, cw(7'h02, 1'b0, p[1:0], 1'b0, 3'h0));
            send(9);
            res(1'b0, 2'b01, exp[p], 12'h0, 3'h3, 1'b0, N_ONE,
                N_ONE);
        end
    endtask

    // Every pairing; the top two come out highest first.
    task automatic t_dual();
        logic [11:0] e0 [4];
        logic [11:0] e1 [4];
        int p;
        e0 = '{12'h001, 12'h001, 12'h004, 12'h004};
        e1 = '{12'h004, 12'h007, 12'h001, 12'h007};
        mk3();
        for (p = 0; p < 4; p++)
        begin
            wr(REG_CTRL, cw(7'h02, 1'b1, p[1:0], 1'b0, 3'h0));
            send(9);
            res(1'b1, 2'b11, e0[p], e1[p], 3'h3, 1'b0, N_ONE,
                N_ONE);
        end
    endtask

    // At 50 % only one peak qualifies, too few for a pair.
    task automatic t_few();
        mk3();
        wr(REG_CTRL, cw(7'h32, 1'b1, 2'h0, 1'b0, 3'h0));
        send(9);
        res(1'b1, 2'b00, 12'h0, 12'h0, 3'h1, 1'b0, N_ONE, N_ONE);
    endtask

    // Layer map and table, then correction on, mismatched and off.
    task automatic t_corr();
        logic [31:0] d;
        wr(REG_CTRL, cw(7'h02, 1'b0, 2'h1, 1'b1, 3'h3));
        wr(REG_LAYER, 32'h00000038);
        rd(REG_LAYER, d);
        chk("layer map", d, 32'h00000038);
        wr(8'h30, 32'h00005550);
        wr(8'h34, 32'h55605540);
        wr(8'h38, 32'h00016000);
        wr(8'h3C, 32'h00400000);
        rd(8'h30, d);
        chk("mat2 a", d, 32'h00005550);
        rd(8'h34, d);
        chk("mat2 b", d, 32'h55605540);
        rd(8'h38, d);
        chk("mat3 a", d, 32'h00016000);
        rd(8'h3C, d);
        chk("mat3 b", d, 32'h00400000);
        mk3();
        send(9);
        res(1'b0, 2'b01, 12'h004, 12'h0, 3'h3, 1'b1, 16'h5550,
            N_ONE);
        wr(REG_CTRL, cw(7'h02, 1'b1, 2'h3, 1'b1, 3'h3));
        send(9);
        res(1'b1, 2'b11, 12'h004, 12'h007, 3'h3, 1'b1, 16'h5550,
            16'h6000);
        rd(REG_STATUS, d);
        chk("status", d, 32'h0000003B);
        rd(REG_RESULT, d);
        chk("result", d, 32'h00070004);
        rd(REG_INDEX, d);
        chk("index", d, 32'h60005550);
        wr(REG_CTRL, cw(7'h02, 1'b1, 2'h3, 1'b1, 3'h2));
        send(9);
        res(1'b1, 2'b11, 12'h004, 12'h007, 3'h3, 1'b0, N_ONE,
            N_ONE);
        wr(REG_CTRL, cw(7'h02, 1'b1, 2'h3, 1'b0, 3'h3));
        send(9);
        res(1'b1, 2'b11, 12'h004, 12'h007, 3'h3, 1'b0, N_ONE,
            N_ONE);
    endtask

    // Main sequence: four reset cycles, then each scenario in turn.
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        t_reset();
        t_thresh();
        t_single();
        t_dual();
        t_few();
        t_corr();
        close_out();
    end
endmodule
